// file: hw/ecs_pkg.sv
// package: register map, field positions and constants for the event counters
package ecs_pkg;
	localparam int          ECS_NUM_CNT     = 16;
	localparam int          ECS_CNT_W       = 32;
	localparam int          ECS_NUM_NET     = 10;
	localparam int          ECS_ADR_W       = 8;
	// register byte offsets; counters occupy 0x00..0x3C
	localparam logic [7:0]  ECS_OFF_CNT0    = 8'h00;
	localparam logic [7:0]  ECS_OFF_FILTER  = 8'h40;
	localparam logic [7:0]  ECS_OFF_SOURCE  = 8'h44;
	localparam logic [7:0]  ECS_OFF_NETCFG  = 8'h48;
	localparam logic [7:0]  ECS_OFF_TRIG    = 8'h4C;
	localparam logic [31:0] ECS_RST_FILTER  = 32'h0000_0000;
	localparam logic [31:0] ECS_RST_SOURCE  = 32'h0000_0000;
	localparam logic [31:0] ECS_RST_NETCFG  = 32'h0000_0000;
	localparam logic [31:0] ECS_RST_CNT     = 32'h0000_0000;
	localparam logic [31:0] ECS_RST_LFSR    = 32'h0000_0001;
	// event_filter_config fields
	localparam int          ECS_FLT_SINGLE  = 0;
	localparam int          ECS_FLT_PC_LO   = 1;
	localparam int          ECS_FLT_PC_HI   = 15;
	localparam int          ECS_FLT_EN_LO   = 16;
	// event_source_select bit positions
	localparam int          ECS_SEL_MISP6   = 2;
	localparam int          ECS_SEL_FUSTALL = 3;
	localparam int          ECS_SEL_GP      = 4;
	localparam int          ECS_SEL_MP      = 5;
	localparam int          ECS_SEL_NCSTALL = 6;
	localparam int          ECS_SEL_GW      = 7;
	localparam int          ECS_SEL_MW      = 8;
	localparam int          ECS_SEL_IMEMOP  = 9;
	localparam int          ECS_SEL_GS      = 10;
	localparam int          ECS_SEL_MS      = 11;
	localparam int          ECS_SEL_STOST   = 12;
	localparam int          ECS_SEL_GNOST   = 13;
	localparam int          ECS_SEL_MNOST   = 14;
	localparam int          ECS_SEL_GE      = 15;
	localparam int          ECS_SEL_ME      = 16;
	localparam int          ECS_SEL_STI1    = 17;
	localparam int          ECS_SEL_STI2    = 18;
	localparam int          ECS_SEL_GNIST   = 19;
	localparam int          ECS_SEL_MNIST   = 20;
	localparam int          ECS_SEL_GN      = 21;
	localparam int          ECS_SEL_MN      = 22;
	localparam int          ECS_SEL_ISSUE1  = 23;
	localparam int          ECS_SEL_ISSUE2  = 24;
	// network event index order within network_event_meaning_config
	localparam int          ECS_NET_GN      = 0;
	localparam int          ECS_NET_GE      = 1;
	localparam int          ECS_NET_GS      = 2;
	localparam int          ECS_NET_GW      = 3;
	localparam int          ECS_NET_GP      = 4;
	localparam int          ECS_NET_MN      = 5;
	localparam int          ECS_NET_ME      = 6;
	localparam int          ECS_NET_MS      = 7;
	localparam int          ECS_NET_MW      = 8;
	localparam int          ECS_NET_MP      = 9;
	localparam logic [2:0]  ECS_MEAN_BLOCK  = 3'h0;
	localparam logic [2:0]  ECS_MEAN_TO_P   = 3'h1;
	localparam logic [2:0]  ECS_MEAN_TO_N   = 3'h5;
	localparam logic [2:0]  ECS_MEAN_ANY    = 3'h6;
	localparam logic [2:0]  ECS_MEAN_HELD   = 3'h7;
	// trigger to interrupt latency in cycles
	localparam int          ECS_IRQ_DLY     = 2;
	typedef enum logic [1:0] {
		ECS_BUS_IDLE = 2'b01,
		ECS_BUS_ACK  = 2'b10
	} ecs_bus_t;
endpackage

// file: hw/ecs_event_counter_select.sv
// event selection, filtering and counter bank with a wishbone register port
`timescale 1ns/100ps
// Functional notes
// - counter 6 counts hint-bit mispredicts when source bit 2 set
// - counters 7-9 count switch events, capture switch pc, ignore filter
// - counter 10 is a 32-bit lfsr, taps 31,30,10,0 into bit 31
// - counter 11 sums selected stall, gp, mp and issue events
// - counter 12 sums non-cache stalls, gw, mw; imem stall pc from rf
// - counter 13 sums imem ops, gs, ms and issue events
// - counter 14 sums output-blocked stalls, ge and me events
// - counter 15 sums input-empty stalls, gn and mn events
// - single-instruction mode counts only events matching pc in bits 15:1
// - events without main pc ignore the single-instruction filter
// - per-counter enables gate counting but keep existing triggers
// - alternative events pick one; listed events add to the set
// - each network event has a 3-bit meaning field
// - meaning 0 counts cycles output port blocked by neighbour
// - meanings 1-5 count words to proc, west, south, east, north
// - meaning 6 counts words leaving input; 7 counts held cycles
// - counters decrement; 0 to -1 sets sticky trigger until written
// - sixteen 32-bit counters, readable and writable
// - event captures pc into bits 31:16; interrupt two cycles later
module ecs_event_counter_select (
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// wishbone classic slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// raw events 0..6 from the pipeline for counters 0..6
	input  wire logic [6:0]  pipe_evt_in,
	input  wire logic        misp_hint_evt_in,
	input  wire logic [2:0]  switch_evt_in,
	input  wire logic        fu_stall_in,
	input  wire logic        noncache_stall_in,
	input  wire logic        imem_stall_in,
	input  wire logic        imem_op_in,
	input  wire logic        issue_in,
	input  wire logic [2:0]  out_block_in,
	input  wire logic [3:0]  in_empty_in,
	// program counters: execute, register fetch, switch (word units)
	input  wire logic [15:0] ex_pc_in,
	input  wire logic [15:0] rf_pc_in,
	input  wire logic [15:0] sw_pc_in,
	// per network event (gn..mp order), router status
	input  wire logic [9:0]  net_out_blocked_in,
	input  wire logic [9:0]  net_held_in,
	input  wire logic [9:0]  net_word_in,
	input  wire logic [29:0] net_word_dest_in,
	output logic      [15:0] trigger_out,
	output logic             event_irq_out
);
	import ecs_pkg::*;

	logic [31:0] cnt_r [ECS_NUM_CNT];
	logic [15:0] trig_r;
	logic [31:0] filter_r;
	logic [31:0] source_r;
	logic [31:0] netcfg_r;
	logic [1:0]  irq_pipe_r;
	ecs_bus_t    bus_r;
	logic [15:0] hit;
	logic [15:0] pc_sel [ECS_NUM_CNT];
	logic [9:0]  net_evt;
	logic        pc_match;
	logic        wr_stb;
	logic [31:0] wmask;
	logic [31:0] rd_nxt;

	always_comb begin
		for (int i = 0; i < ECS_NUM_NET; i++) begin
			logic [2:0] m;
			logic [2:0] d;
			m = netcfg_r[3*i +: 3];
			d = net_word_dest_in[3*i +: 3];
			case (m)
				ECS_MEAN_BLOCK: net_evt[i] = net_out_blocked_in[i];
				ECS_MEAN_ANY:   net_evt[i] = net_word_in[i];
				ECS_MEAN_HELD:  net_evt[i] = net_held_in[i];
				// destination code matches the meaning 1..5
				default:        net_evt[i] = net_word_in[i] && (d == m);
			endcase
		end
	end

	// pc in filter bits 15:1 against execute pc
	assign pc_match = !filter_r[ECS_FLT_SINGLE] ||
		(ex_pc_in[14:0] == filter_r[ECS_FLT_PC_HI:ECS_FLT_PC_LO]);

	// event selection per counter; '@' sources bypass pc_match
	always_comb begin
		logic [15:0] ok;
		ok = {16{pc_match}};
		for (int i = 0; i < ECS_NUM_CNT; i++) begin
			pc_sel[i] = ex_pc_in;
		end
		hit[5:0] = pipe_evt_in[5:0] & ok[5:0];
		hit[6] = ok[6] & (source_r[ECS_SEL_MISP6] ? misp_hint_evt_in
			: pipe_evt_in[6]);
		// switch events, switch pc, no filter
		hit[9:7] = switch_evt_in;
		pc_sel[7] = sw_pc_in;
		pc_sel[8] = sw_pc_in;
		pc_sel[9] = sw_pc_in;
		hit[10] = 1'b0;
		hit[11] = (source_r[ECS_SEL_FUSTALL] & fu_stall_in & ok[11])
			| (source_r[ECS_SEL_GP] & net_evt[ECS_NET_GP])
			| (source_r[ECS_SEL_MP] & net_evt[ECS_NET_MP])
			| (source_r[ECS_SEL_ISSUE1] & issue_in);
		hit[12] = (source_r[ECS_SEL_NCSTALL] & noncache_stall_in & ok[12])
			| (source_r[ECS_SEL_GW] & net_evt[ECS_NET_GW])
			| (source_r[ECS_SEL_MW] & net_evt[ECS_NET_MW]);
		if (imem_stall_in) begin
			pc_sel[12] = rf_pc_in;
		end
		hit[13] = (source_r[ECS_SEL_IMEMOP] & imem_op_in & ok[13])
			| (source_r[ECS_SEL_GS] & net_evt[ECS_NET_GS])
			| (source_r[ECS_SEL_MS] & net_evt[ECS_NET_MS])
			| (source_r[ECS_SEL_ISSUE2] & issue_in);
		hit[14] = (ok[14] & |(source_r[ECS_SEL_MNOST:ECS_SEL_STOST]
				& out_block_in))
			| (source_r[ECS_SEL_GE] & net_evt[ECS_NET_GE])
			| (source_r[ECS_SEL_ME] & net_evt[ECS_NET_ME]);
		hit[15] = (ok[15] & |(source_r[ECS_SEL_MNIST:ECS_SEL_STI1]
				& in_empty_in))
			| (source_r[ECS_SEL_GN] & net_evt[ECS_NET_GN])
			| (source_r[ECS_SEL_MN] & net_evt[ECS_NET_MN]);
		hit = hit & filter_r[31:ECS_FLT_EN_LO];
	end

	// bus decode
	assign wr_stb = wb_cyc_in && wb_stb_in && wb_we_in
		&& (bus_r == ECS_BUS_IDLE);
	assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
		{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

	// counter bank; written counter clears its trigger
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < ECS_NUM_CNT; i++) begin
				cnt_r[i] <= (i == 10) ? ECS_RST_LFSR : ECS_RST_CNT;
			end
			trig_r <= 16'h0000;
		end else begin
			for (int i = 0; i < ECS_NUM_CNT; i++) begin
				logic [31:0] dec;
				dec = cnt_r[i] - 32'h0000_0001;
				if (wr_stb && wb_adr_in[7:6] == 2'b00
					&& wb_adr_in[5:2] == 4'(i)) begin
					cnt_r[i] <= (cnt_r[i] & ~wmask) | (wb_dat_in & wmask);
					trig_r[i] <= 1'b0;
				end else if (i == 10) begin
					cnt_r[i] <= {cnt_r[i][31] ^ cnt_r[i][30] ^ cnt_r[i][10]
						^ cnt_r[i][0], cnt_r[i][31:1]};
				end else if (hit[i]) begin
					cnt_r[i] <= {pc_sel[i], dec[15:0]};
					if (cnt_r[i][15:0] == 16'h0000) begin
						trig_r[i] <= 1'b1;
					end
				end
			end
		end
	end

	// interrupt two cycles after a trigger
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			irq_pipe_r <= 2'b00;
		end else begin
			irq_pipe_r <= {irq_pipe_r[0], |trig_r};
		end
	end
	assign event_irq_out = irq_pipe_r[1];
	assign trigger_out = trig_r;

	// configuration registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			filter_r <= ECS_RST_FILTER;
			source_r <= ECS_RST_SOURCE;
			netcfg_r <= ECS_RST_NETCFG;
		end else if (wr_stb) begin
			case (wb_adr_in)
				ECS_OFF_FILTER: filter_r <= (filter_r & ~wmask)
					| (wb_dat_in & wmask);
				ECS_OFF_SOURCE: source_r <= (source_r & ~wmask)
					| (wb_dat_in & wmask);
				// only ten 3-bit fields exist
				ECS_OFF_NETCFG: netcfg_r <= ((netcfg_r & ~wmask)
					| (wb_dat_in & wmask)) & 32'h3FFF_FFFF;
				default: ;
			endcase
		end
	end

	// read mux; unmapped reads return zero and still ack
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (wb_adr_in[7:6] == 2'b00) begin
			rd_nxt = cnt_r[wb_adr_in[5:2]];
		end else begin
			case (wb_adr_in)
				ECS_OFF_FILTER: rd_nxt = filter_r;
				ECS_OFF_SOURCE: rd_nxt = source_r;
				ECS_OFF_NETCFG: rd_nxt = netcfg_r;
				ECS_OFF_TRIG:   rd_nxt = {16'h0000, trig_r};
				default:        rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	// one-cycle ack, dropped the cycle after
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			bus_r      <= ECS_BUS_IDLE;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			case (bus_r)
				ECS_BUS_IDLE: if (wb_cyc_in && wb_stb_in) begin
					bus_r      <= ECS_BUS_ACK;
					wb_dat_out <= rd_nxt;
				end
				ECS_BUS_ACK: bus_r <= ECS_BUS_IDLE;
				default: bus_r <= ECS_BUS_IDLE;
			endcase
		end
	end
	assign wb_ack_out = (bus_r == ECS_BUS_ACK);

	AST_IRQ_DELAY: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(|trig_r) |-> ##2 event_irq_out)
		else $error("irq not two cycles after trigger");
	AST_TRIG_STICKY: assert property (@(posedge clock_in) disable iff (rst_in)
		(trig_r[11] && !(wr_stb && wb_adr_in == 8'h2C)) |=> trig_r[11])
		else $error("trigger dropped without write");
	AST_LFSR_STEP: assert property (@(posedge clock_in) disable iff (rst_in)
		!(wr_stb && wb_adr_in == 8'h28) |=> cnt_r[10][30:0]
		== $past(cnt_r[10][31:1]))
		else $error("lfsr shift wrong");
	AST_DISABLED_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
		(!filter_r[27] && !(wr_stb && wb_adr_in == 8'h2C))
		|=> $stable(cnt_r[11]))
		else $error("disabled counter moved");
	AST_DEC_ON_EVENT: assert property (@(posedge clock_in) disable iff (rst_in)
		(hit[15] && !wr_stb) |=> cnt_r[15][15:0]
		== $past(cnt_r[15][15:0]) - 16'h0001)
		else $error("counter did not decrement");
	AST_SW_PC: assert property (@(posedge clock_in) disable iff (rst_in)
		(hit[8] && !wr_stb) |=> cnt_r[8][31:16] == $past(sw_pc_in))
		else $error("switch pc not captured");
	AST_FILTER: assert property (@(posedge clock_in) disable iff (rst_in)
		(filter_r[0] && !pc_match && !source_r[ECS_SEL_MISP6]) |-> !hit[6])
		else $error("filtered event counted");
	AST_HINT_SEL: assert property (@(posedge clock_in) disable iff (rst_in)
		(source_r[ECS_SEL_MISP6] && !misp_hint_evt_in) |-> !hit[6])
		else $error("counter 6 selection wrong");
	AST_NET_BLOCK: assert property (@(posedge clock_in) disable iff (rst_in)
		(netcfg_r[2:0] == 3'h0) |-> net_evt[0] == net_out_blocked_in[0])
		else $error("block meaning wrong");
	AST_ACK_PULSE: assert property (@(posedge clock_in) disable iff (rst_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
endmodule

// file: test/ecs_net_model.sv
// router model: replays one fixed burst of port events on one index
`timescale 1ns/100ps
module ecs_net_model (
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic        start_in,
	input  wire logic [3:0]  idx_in,
	output logic             done_out,
	output logic      [9:0]  blocked_out,
	output logic      [9:0]  held_out,
	output logic      [9:0]  word_out,
	output logic      [29:0] dest_out
);
	logic [3:0] step_r;
	logic [2:0] junk_r;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			step_r <= 4'hF;
			junk_r <= 3'h0;
		end else begin
			junk_r <= junk_r + 3'h3;
			if (start_in)
				step_r <= 4'h0;
			else if (step_r != 4'hF)
				step_r <= step_r + 4'h1;
		end
	end
	always_comb begin
		blocked_out = '0;
		held_out = '0;
		word_out = '0;
		// dest means nothing without a word, so keep it moving
		dest_out = {10{junk_r}};
		done_out = (step_r == 4'h7);
		if (step_r == 4'h0)
			blocked_out[idx_in] = 1'b1;
		if (step_r == 4'h1)
			held_out[idx_in] = 1'b1;
		if (step_r >= 4'h2 && step_r <= 4'h6) begin
			word_out[idx_in] = 1'b1;
			dest_out[3*idx_in +: 3] = step_r[2:0] - 3'h1;
		end
	end
endmodule

// file: test/ecs_event_counter_select_tb.sv
// self-checking bench for the event counter select block
`timescale 1ns/100ps
module ecs_event_counter_select_tb;
	import ecs_pkg::*;
	logic        clock_in, rst_in, cyc, stb, we, ack, start, irq, done;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, dout;
	logic [22:0] ev;
	logic [15:0] ex_pc, sw_pc, rf_pc, trig;
	logic [3:0]  idx;
	logic [9:0]  blk, held, word;
	logic [29:0] dest;
	int          miscompares, n_compared;
	ecs_event_counter_select u_dut (
		.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
		.wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack),
		.pipe_evt_in(ev[6:0]), .misp_hint_evt_in(ev[7]),
		.switch_evt_in(ev[10:8]), .fu_stall_in(ev[11]),
		.noncache_stall_in(ev[12]), .imem_stall_in(ev[13]),
		.imem_op_in(ev[14]), .issue_in(ev[15]), .out_block_in(ev[18:16]),
		.in_empty_in(ev[22:19]), .ex_pc_in(ex_pc), .rf_pc_in(rf_pc),
		.sw_pc_in(sw_pc), .net_out_blocked_in(blk), .net_held_in(held),
		.net_word_in(word), .net_word_dest_in(dest), .trigger_out(trig),
		.event_irq_out(irq));
	ecs_net_model u_net (.clock_in(clock_in), .rst_in(rst_in),
		.start_in(start), .idx_in(idx), .done_out(done), .blocked_out(blk),
		.held_out(held), .word_out(word), .dest_out(dest));
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clock_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			$display("[ERR] ack expected 1 seen 0");
		end
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pulse(input int b);
		@(posedge clock_in);
		ev <= 23'h1 << b;
		@(posedge clock_in);
		ev <= '0;
	endtask
	task automatic t_reset;
		rd(ECS_OFF_FILTER);
		chk("filter", ECS_RST_FILTER, rdat);
		rd(ECS_OFF_SOURCE);
		chk("source", ECS_RST_SOURCE, rdat);
		rd(ECS_OFF_NETCFG);
		chk("netcfg", ECS_RST_NETCFG, rdat);
		rd(8'h80);
		chk("unmapped", 32'h0, rdat);
		wr(ECS_OFF_CNT0 + 8'h0C, 32'h1234_5678);
		rd(ECS_OFF_CNT0 + 8'h0C);
		chk("cnt3", 32'h1234_5678, rdat);
	endtask
	task automatic t_trig;
		wr(ECS_OFF_FILTER, 32'h0001_0000);
		wr(ECS_OFF_CNT0, 32'h0);
		ex_pc <= 16'h0123;
		pulse(0);
		rd(ECS_OFF_CNT0);
		chk("cnt0", 32'h0123_FFFF, rdat);
		repeat (3) @(posedge clock_in);
		chk("trig", 32'h1, {16'h0, trig});
		chk("irq", 32'h1, {31'h0, irq});
		wr(ECS_OFF_FILTER, 32'h0);
		pulse(0);
		rd(ECS_OFF_CNT0);
		chk("gated", 32'h0123_FFFF, rdat);
		chk("trig kept", 32'h1, {16'h0, trig});
		wr(ECS_OFF_CNT0, 32'h5);
		repeat (2) @(posedge clock_in);
		chk("trig clr", 32'h0, {16'h0, trig});
	endtask
	task automatic t_table;
		int c[16] = '{6, 7, 8, 9, 11, 11, 12, 13, 13, 14, 14, 14, 15, 15, 15, 15};
		int s[16] = '{2, 0, 0, 0, 3, 23, 6, 9, 24, 12, 13, 14, 17, 18, 19, 20};
		int e[16] = '{7, 8, 9, 10, 11, 15, 12, 14, 15, 16, 17, 18, 19, 20, 21, 22};
		wr(ECS_OFF_FILTER, 32'hFFFF_0000);
		for (int i = 0; i < 16; i++) begin
			wr(ECS_OFF_SOURCE, 32'h0);
			wr(ECS_OFF_CNT0 + 8'(4 * c[i]), 32'd100);
			pulse(e[i]);
			wr(ECS_OFF_SOURCE, (s[i] == 0) ? 32'h0 : 32'h1 << s[i]);
			pulse(e[i]);
			// alternative event must drop out once the select flips
			if (c[i] == 6)
				pulse(6);
			rd(ECS_OFF_CNT0 + 8'(4 * c[i]));
			chk("cnt", 32'(100 - ((s[i] == 0) ? 2 : 1)),
				{16'h0, rdat[15:0]});
		end
	endtask
	task automatic t_filter;
		wr(ECS_OFF_FILTER, 32'hFFFF_0081);
		wr(ECS_OFF_CNT0 + 8'h10, 32'd100);
		wr(ECS_OFF_CNT0 + 8'h1C, 32'd100);
		sw_pc <= 16'h0ABC;
		ex_pc <= 16'h0041;
		pulse(4);
		pulse(8);
		ex_pc <= 16'h0040;
		pulse(4);
		ex_pc <= 16'h0041;
		rd(ECS_OFF_CNT0 + 8'h10);
		chk("single", 32'h63, {16'h0, rdat[15:0]});
		rd(ECS_OFF_CNT0 + 8'h1C);
		chk("swpc", 32'h0ABC_0063, rdat);
		// imem stall: captured pc comes from register fetch
		rf_pc <= 16'h0777;
		wr(ECS_OFF_FILTER, 32'hFFFF_0000);
		wr(ECS_OFF_SOURCE, 32'h1 << ECS_SEL_NCSTALL);
		wr(ECS_OFF_CNT0 + 8'h30, 32'd100);
		@(posedge clock_in);
		ev <= 23'h3000;
		@(posedge clock_in);
		ev <= '0;
		rd(ECS_OFF_CNT0 + 8'h30);
		chk("rfpc", 32'h0777_0063, rdat);
	endtask
	task automatic t_lfsr;
		logic [31:0] x;
		int hit;
		hit = 0;
		rd(ECS_OFF_CNT0 + 8'h28);
		x = rdat;
		rd(ECS_OFF_CNT0 + 8'h28);
		for (int j = 0; j < 64; j++) begin
			x = {x[31] ^ x[30] ^ x[10] ^ x[0], x[31:1]};
			if (x === rdat)
				hit = 1;
		end
		chk("lfsr", 32'h1, 32'(hit));
	endtask
	task automatic t_net;
		int id, n;
		for (int k = 0; k < 2; k++) begin
			id = k ? 5 : 0;
			for (int m = 0; m < 8; m++) begin
				wr(ECS_OFF_NETCFG, 32'(m) << (3 * id));
				wr(ECS_OFF_SOURCE, 32'h1 << (k ? 22 : 21));
				wr(ECS_OFF_CNT0 + 8'h3C, 32'd100);
				start <= 1'b1;
				idx <= 4'(id);
				@(posedge clock_in);
				start <= 1'b0;
				n = 0;
				while (done !== 1'b1 && n < 20) begin
					@(posedge clock_in);
					n++;
				end
				rd(ECS_OFF_CNT0 + 8'h3C);
				chk("net", 32'(100 - ((m == 6) ? 5 : 1)),
					{16'h0, rdat[15:0]});
			end
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	initial begin
		{cyc, stb, we, start, adr, wdat, ev, ex_pc, sw_pc, rf_pc, idx} = '0;
		rst_in = 1'b1;
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		t_reset;
		t_trig;
		t_table;
		t_filter;
		t_lfsr;
		t_net;
		end_of_test;
	end
	// whole run needs about 700 cycles
	initial begin
		#1000000;
		miscompares++;
		end_of_test;
	end
endmodule
